/* src/adp_pkg.sv */
// package of constants and types for the adc serial readout port
`default_nettype none

package adp_pkg;

  // serial word layout
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned RES_BITS  = 18;        // sign_flag plus 17 result bits
  localparam int unsigned SIN_BITS  = 16;
  localparam int unsigned CNT_W     = 5;
  localparam int unsigned DIV_W     = 5;

  localparam logic [CNT_W-1:0] CNT_LAST   = 5'h18;  // 24 clock pulses per word
  localparam logic [CNT_W-1:0] CNT_CHAN   = 5'h08;  // bits needed for a channel update
  localparam logic [CNT_W-1:0] CNT_CFG    = 5'h10;  // bits needed for a config update
  localparam logic [CNT_W-1:0] CNT_SIN    = 5'h10;  // input bits captured

  // input word fields, index into the capture register
  localparam int unsigned PRE_MSB  = 15;
  localparam int unsigned PRE_LSB  = 13;
  localparam int unsigned CHAN_MSB = 12;
  localparam int unsigned CHAN_LSB = 8;
  localparam int unsigned EN2_POS  = 7;
  localparam int unsigned CFG_MSB  = 6;
  localparam logic [2:0]  PRE_APPLY = 3'h5;          // preamble 101

  // values after reset: ch0 positive, ch1 negative, 50/60 Hz, 1x rate, gain 1
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [6:0] CFG_RST  = 7'h00;
  localparam logic       STATUS_RST = 1'b1;  // reset leaves a conversion running, status busy

  // clamp codes for out-of-range inputs
  localparam logic [RES_BITS-1:0] RES_OVER  = 18'h3_0000;
  localparam logic [RES_BITS-1:0] RES_UNDER = 18'h0_FFFF;

  // internal serial clock rate
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned SCK_HALF_NS     = 500;
  localparam int unsigned SCK_HALF_CYC_I  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [DIV_W-1:0] SCK_HALF_CYC = DIV_W'(SCK_HALF_CYC_I);

  // converter cycle, gray coded along conv -> sleep -> transfer
  typedef enum logic [1:0] {
    ADP_CONV  = 2'h0,
    ADP_SLEEP = 2'h1,
    ADP_XFER  = 2'h3
  } adp_state_t;

  typedef struct packed {
    adp_state_t            st;
    logic [CNT_W-1:0]      cnt;
    logic [DIV_W-1:0]      div;
    logic                  isck;
    logic                  ext;
    logic                  mode_seen;
    logic                  cs_d;
    logic                  sck_d;
    logic [WORD_BITS-1:0]  word;
    logic [SIN_BITS-1:0]   sin;
    logic [4:0]            chan;
    logic [6:0]            cfg;
    logic                  start;
    logic                  serial_out_line;
    logic                  sdo_oe;
    logic                  sck_oe;
  } adp_regs_t;

endpackage

`default_nettype wire

/* src/adp_sync.sv */
// two-flop synchroniser bank for the serial pins
`timescale 1ns/10ps
`default_nettype none

module adp_sync #(
  parameter int unsigned W = 3
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage; reset to the idle-high pin levels
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= '1;
      o_sync <= '1;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

`default_nettype wire

/* src/adp_port.sv */
// serial readout and control port of a delta-sigma converter
//
// Behaviour
// - output bits change on serial clock fall
// - input sampled on rise, transfer state only
// - clock pin level picks internal/external clock
// - chip select high: output off, clock ignored
// - status on output: high converting, low ready
// - status drops when conversion completes, no clock
// - sleep holding result until chip select falls
// - new conversion after 24 bits or abort
// - word: status, zero, sign, 17 bits, padding
// - four lowest bits zero, result lsb bit 4
// - sign high for zero or positive input
// - sign and msb pair flag over/under range
// - out-of-range results clamped one lsb beyond
// - host reads status first, last on 24th
// - 24th fall drives output high
// - early select rise returns to sleep
// - power-up defaults ch0/ch1, 50/60, 1x, gain 1
// - preamble 101 applies settings, else keep
`timescale 1ns/10ps
`default_nettype none

module adp_port
  import adp_pkg::*;
(
  // clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  // serial pins from the host
  input  wire logic                i_cs_n,
  input  wire logic                i_serial_clk,
  input  wire logic                i_serial_in_line,
  // serial pins to the host
  output logic                     o_serial_out_line,
  output logic                     o_serial_out_line_oe,
  output logic                     o_serial_clk,
  output logic                     o_serial_clk_oe,
  // converter core
  input  wire logic                i_conv_done,
  input  wire logic [RES_BITS-1:0] i_conv_data,
  input  wire logic                i_conv_over,
  input  wire logic                i_conv_under,
  output logic                     o_conv_start,
  output logic [4:0]               o_chan_sel,
  output logic [6:0]               o_conv_cfg,
  output logic                     o_ext_clk_mode
);

  adp_regs_t  s_r;
  adp_regs_t  s_nxt;
  logic [2:0] pins_s;
  logic       cs_s;
  logic       sck_s;
  logic       sdi_s;
  logic       tick;
  logic       int_run;
  logic       int_rise;
  logic       int_fall;
  logic       rise;
  logic       fall;
  logic       go;

  // result word: status low, filler_zero_bit, clamped result, zero padding
  function automatic logic [WORD_BITS-1:0] build_word(
    input logic [RES_BITS-1:0] data,
    input logic                over,
    input logic                under
  );
    logic [RES_BITS-1:0] res;
    res = over ? RES_OVER : (under ? RES_UNDER : data);
    build_word = {2'h0, res, 4'h0};
  endfunction

  // every pin passes two flops before use
  adp_sync #(.W(3)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_cs_n, i_serial_clk, i_serial_in_line}),
    .o_sync    (pins_s)
  );

  assign cs_s  = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // next-state logic for the whole port
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    s_nxt.cs_d  = cs_s;
    s_nxt.sck_d = sck_s;
    go          = 1'b0;
    // a floating pin reads high and means internal clock
    if (!s_r.mode_seen || (s_r.cs_d && !cs_s))
    begin
      s_nxt.mode_seen = 1'b1;
      s_nxt.ext       = !sck_s;
    end
    // internal clock: stops after 24 pulses, high phase finished unless select rises during it
    tick     = (s_r.div == SCK_HALF_CYC - 5'h01);
    int_run  = (s_r.st == ADP_XFER) && !s_r.ext && !cs_s
               && ((s_r.cnt < CNT_LAST) || s_r.isck);
    s_nxt.div = (int_run && !tick) ? s_r.div + 5'h01 : 5'h00;
    int_rise = int_run && tick && !s_r.isck;
    int_fall = int_run && tick && s_r.isck;
    if (int_rise)
    begin
      s_nxt.isck = 1'b1;
    end
    if (int_fall)
    begin
      s_nxt.isck = 1'b0;
    end
    // clock activity counts only in transfer with select low
    rise = (s_r.st == ADP_XFER) && !cs_s
           && (s_r.ext ? (sck_s && !s_r.sck_d) : int_rise);
    fall = (s_r.st == ADP_XFER) && !cs_s
           && (s_r.ext ? (!sck_s && s_r.sck_d) : int_fall);
    case (s_r.st)
      ADP_CONV:
      begin
        if (i_conv_done)
        begin
          s_nxt.st   = ADP_SLEEP;
          s_nxt.word = build_word(i_conv_data, i_conv_over, i_conv_under);
        end
      end
      ADP_SLEEP:
      begin
        if (!cs_s)
        begin
          s_nxt.st   = ADP_XFER;
          s_nxt.cnt  = '0;
          s_nxt.sin  = '0;
          s_nxt.isck = 1'b0;
        end
      end
      ADP_XFER:
      begin
        if (cs_s)
        begin
          // select rise before the first rise keeps the result
          if (s_r.cnt == '0)
          begin
            s_nxt.st = ADP_SLEEP;
          end
          else
          begin
            go = 1'b1;
          end
        end
        else
        begin
          if (rise && (s_r.cnt < CNT_LAST))
          begin
            s_nxt.cnt = s_r.cnt + 5'h01;
            if (s_r.cnt < CNT_SIN)
            begin
              s_nxt.sin[4'(PRE_MSB) - s_r.cnt[3:0]] = sdi_s;
            end
          end
          if (fall && (s_r.cnt != '0))
          begin
            if (s_r.cnt == CNT_LAST)
            begin
              go = 1'b1;
            end
            else
            begin
              s_nxt.word = {s_r.word[WORD_BITS-2:0], 1'b0};
            end
          end
        end
      end
      default:
      begin
        s_nxt.st = ADP_CONV;
      end
    endcase
    // start a conversion; settings only move with a full preamble 101
    if (go)
    begin
      s_nxt.st    = ADP_CONV;
      s_nxt.start = 1'b1;
      s_nxt.isck  = 1'b0;
      if ((s_r.sin[PRE_MSB:PRE_LSB] == PRE_APPLY) && (s_r.cnt >= CNT_CHAN))
      begin
        s_nxt.chan = s_r.sin[CHAN_MSB:CHAN_LSB];
      end
      if ((s_r.sin[PRE_MSB:PRE_LSB] == PRE_APPLY) && (s_r.cnt >= CNT_CFG)
          && s_r.sin[EN2_POS])
      begin
        s_nxt.cfg = s_r.sin[CFG_MSB:0];
      end
    end
    // output pin: status outside transfer, word msb inside it
    case (s_nxt.st)
      ADP_CONV:  s_nxt.serial_out_line = 1'b1;
      ADP_SLEEP: s_nxt.serial_out_line = 1'b0;
      default:   s_nxt.serial_out_line = s_nxt.word[WORD_BITS-1];
    endcase
    s_nxt.sdo_oe = !cs_s;
    s_nxt.sck_oe = (s_nxt.st == ADP_XFER) && !s_nxt.ext && !cs_s;
  end

  // single state register; reset leaves a conversion running on defaults
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r      <= '0;
      s_r.chan <= CHAN_RST;
      s_r.cfg  <= CFG_RST;
      s_r.serial_out_line  <= STATUS_RST;
      s_r.cs_d  <= 1'b1;  // idle pin levels, so no false edge follows reset
      s_r.sck_d <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_serial_out_line    = s_r.serial_out_line;
  assign o_serial_out_line_oe = s_r.sdo_oe;
  assign o_serial_clk         = s_r.isck;
  assign o_serial_clk_oe      = s_r.sck_oe;
  assign o_conv_start         = s_r.start;
  assign o_chan_sel           = s_r.chan;
  assign o_conv_cfg           = s_r.cfg;
  assign o_ext_clk_mode       = s_r.ext;

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_shift_on_fall: assert property (
    fall && (s_r.cnt != '0) && (s_r.cnt != CNT_LAST)
    |=> s_r.word == {$past(s_r.word[WORD_BITS-2:0]), 1'b0})
    else $error("word did not shift on clock fall");
  a_first_sample: assert property (
    rise && (s_r.cnt == '0) |=> s_r.sin[PRE_MSB] == $past(sdi_s))
    else $error("first input bit not captured");
  a_mode_pick: assert property (
    s_r.mode_seen && s_r.cs_d && !cs_s |=> s_r.ext == !$past(sck_s))
    else $error("clock mode not taken at select fall");
  a_hiz_select: assert property (
    cs_s ##1 cs_s |-> !o_serial_out_line_oe && !o_serial_clk_oe)
    else $error("pins driven with select high");
  a_busy_status: assert property (
    (s_r.st == ADP_CONV) |-> o_serial_out_line)
    else $error("status not high while converting");
  a_done_drop: assert property (
    (s_r.st == ADP_CONV) && i_conv_done |=> (s_r.st == ADP_SLEEP) && !o_serial_out_line)
    else $error("status did not fall at completion");
  a_word_pad: assert property (
    (s_r.st == ADP_CONV) && i_conv_done |=> s_r.word[3:0] == 4'h0 && s_r.word[23:22] == 2'h0)
    else $error("padding or filler bits not zero");
  a_clamp_over: assert property (
    (s_r.st == ADP_CONV) && i_conv_done && i_conv_over |=> s_r.word[21:4] == RES_OVER)
    else $error("over range not clamped");
  a_abort_start: assert property (
    (s_r.st == ADP_XFER) && cs_s && (s_r.cnt != '0) |=> o_conv_start ##1 !o_conv_start)
    else $error("abort did not start one conversion");
  a_early_sleep: assert property (
    (s_r.st == ADP_XFER) && cs_s && (s_r.cnt == '0) |=> (s_r.st == ADP_SLEEP) && !o_conv_start)
    else $error("early select rise left sleep");
  a_last_fall: assert property (
    fall && (s_r.cnt == CNT_LAST) |=> o_serial_out_line && o_conv_start)
    else $error("24th fall did not raise output");
  a_pulse_limit: assert property (
    $rose(o_serial_clk) |-> o_serial_clk_oe && (s_r.cnt != '0) && (s_r.cnt <= CNT_LAST))
    else $error("internal clock beyond 24 pulses");

  c_full_read:   cover property (fall && (s_r.cnt == CNT_LAST));
  c_abort:       cover property ((s_r.st == ADP_XFER) && cs_s && (s_r.cnt != '0));
  c_early_exit:  cover property ((s_r.st == ADP_XFER) && cs_s && (s_r.cnt == '0));
  c_internal:    cover property (int_rise && (s_r.cnt == CNT_LAST - 5'h01));

endmodule

`default_nettype wire

/* tb/adp_host.sv */
// host controller model driving select, serial clock and data in
`timescale 1ns/10ps
`default_nettype none

module adp_host (
  // clock and device data out
  input  wire logic i_clk_sys,
  input  wire logic i_sdo,
  // pins driven by the host
  output var  logic o_cs_n,
  output var  logic o_sck,
  output var  logic o_sck_oe,
  output var  logic o_sdi
);
  // pins idle: select high, clock driven low
  initial
  begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_sck_oe = 1'b1;
    o_sdi    = 1'b0;
  end

  // wait whole cycles, then move off the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // one frame of n pulses, 400 ns each, data latched just before each rise
  task automatic xfer(input logic [15:0] din, input int n,
                      output logic [23:0] dout, output logic tail);
    dout     = '0;
    o_sck_oe = 1'b1;  // clock held low at select fall picks external mode
    o_sck    = 1'b0;
    step(1);
    o_cs_n = 1'b0;  // select before any clocking
    step(12);
    for (int i = 0; i < n; i++)
    begin
      o_sdi = (i < 16) ? din[15-i] : ~o_sdi;  // word only 16 bits long
      step(8);
      dout[23-i] = i_sdo;  // status first, last bit before 24th rise
      o_sck      = 1'b1;
      step(8);
      o_sck = 1'b0;
    end
    step(12);
    tail   = i_sdo;
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi;  // a released line must not keep its last value
    step(8);
  endtask
endmodule

`default_nettype wire

/* tb/adp_port_bench.sv */
// self-checking bench for the adc serial readout port
`timescale 1ns/10ps
`default_nettype none

module adp_port_bench;
  import adp_pkg::*;

  logic                clk;
  logic                rst;
  logic                done;
  logic [RES_BITS-1:0] data;
  logic                ovr;
  logic                und;
  wire logic           cs_n, h_sck, h_oe, serial_in_line;
  logic                serial_out_line, sdo_oe, d_sck, d_oe, start, ext;
  logic [4:0]          chan;
  logic [6:0]          cfg;
  logic [23:0]         w, icap = '0;
  logic                tail;
  int                  bad_count = 0;
  int                  checks = 0;
  int                  starts = 0;
  int                  pulses = 0;
  int                  cyc = 0;
  int                  s0;
  // floating clock pin reads high when nobody drives it
  wire logic sck_w = d_oe ? d_sck : (h_oe ? h_sck : 1'b1);
  // a released data line shows the inverse of the last bit, so late sampling shows up
  wire logic sdo_pin = sdo_oe ? serial_out_line : ~serial_out_line;

  adp_host i_adp_host (.i_clk_sys(clk), .i_sdo(sdo_pin), .o_cs_n(cs_n), .o_sck(h_sck),
                       .o_sck_oe(h_oe), .o_sdi(serial_in_line));
  adp_port i_adp_port (.i_clk_sys(clk), .i_rst(rst), .i_cs_n(cs_n), .i_serial_clk(sck_w),
    .i_serial_in_line(serial_in_line), .o_serial_out_line(serial_out_line), .o_serial_out_line_oe(sdo_oe),
    .o_serial_clk(d_sck), .o_serial_clk_oe(d_oe), .i_conv_done(done), .i_conv_data(data),
    .i_conv_over(ovr), .i_conv_under(und), .o_conv_start(start), .o_chan_sel(chan),
    .o_conv_cfg(cfg), .o_ext_clk_mode(ext));

  // 25 ns system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count start pulses, cycles, and internal clock pulses with their data
  always @(posedge clk)
  begin
    starts += int'(start === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  always @(posedge d_sck)
  begin
    pulses++;
    icap = {icap[22:0], serial_out_line};
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // finished conversion from the core, one-cycle pulse
  task automatic conv(input logic [RES_BITS-1:0] d, input logic o, input logic u);
    data = d;
    ovr  = o;
    und  = u;
    done = 1'b1;
    i_adp_host.step(1);
    done = 1'b0;
    i_adp_host.step(1);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    rst  = 1'b1;
    done = 1'b0;
    data = '0;
    ovr  = 1'b0;
    und  = 1'b0;
    i_adp_host.step(3);
    rst = 1'b0;
    i_adp_host.step(6);
    // status while converting, then drop on completion with no clock
    i_adp_host.o_cs_n = 1'b0;
    i_adp_host.step(8);
    chk(sdo_oe, 1);
    chk(serial_out_line, 1);
    conv(18'h2_A5C3, 1'b0, 1'b0);
    chk(serial_out_line, 0);
    i_adp_host.o_cs_n = 1'b1;
    i_adp_host.step(8);
    chk(sdo_oe, 0);
    chk(chan, 32'h0);
    chk(cfg, 32'h0);
    s0 = starts;
    i_adp_host.xfer({3'h5, 5'h11, 1'b1, 7'h55}, 24, w, tail);
    chk(ext, 1);
    chk(w, {8'h00, 2'h0, 18'h2_A5C3, 4'h0});
    chk(tail, 1);
    chk(starts - s0, 1);
    chk(chan, 32'h11);
    chk(cfg, 32'h55);
    $display("test full readout done");
    // out of range codes; preamble 100 keeps all, 101 with en2 low moves channel only
    for (int k = 0; k < 2; k++)
    begin
      conv(18'h1_2345, k == 0, k == 1);
      i_adp_host.xfer((k == 0) ? 16'h8FFF : {3'h5, 5'h03, 1'b0, 7'h7F}, 24, w, tail);
      chk(w[21:4], (k == 0) ? 18'h3_0000 : 18'h0_FFFF);
      chk(chan, (k == 0) ? 32'h11 : 32'h03);
      chk(cfg, 32'h55);
    end
    $display("test clamp done");
    // select pulse with no clock, then abort after five bits
    conv(18'h1_8000, 1'b0, 1'b0);
    s0 = starts;
    i_adp_host.xfer(16'h0000, 0, w, tail);
    chk(starts - s0, 0);
    i_adp_host.xfer(16'h0000, 5, w, tail);
    chk(w[23:19], 5'h03);
    chk(starts - s0, 1);
    $display("test abort done");
    // internal clock: pin floats high at select fall
    conv(18'h0_4321, 1'b0, 1'b0);
    pulses = 0;
    i_adp_host.o_sdi = 1'b0;  // preamble 000 keeps settings
    i_adp_host.o_sck_oe = 1'b0;
    i_adp_host.step(1);
    i_adp_host.o_cs_n = 1'b0;
    i_adp_host.step(1200);
    chk(ext, 0);
    chk(pulses, 24);
    chk(icap, {2'h0, 18'h0_4321, 4'h0});
    chk(serial_out_line, 1);
    i_adp_host.o_cs_n = 1'b1;
    i_adp_host.o_sck_oe = 1'b1;
    i_adp_host.step(8);
    chk(d_oe, 0);
    $display("test internal clock done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
